// ### hdl/adccr_top.sv
`timescale 1ns/100ps
module adccr_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic config_serial_in,
  input wire logic readout_clock,
  input wire logic chain_serial_in,
  input wire logic adc_results_valid,
  input wire logic [adccr_pkg::TDM_BITS-1:0] adc_results,
  output adccr_pkg::adccr_cfg_t converter_configuration,
  output adccr_pkg::adccr_dout_t data_out,
  output logic result_ready_n
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic cfg_meta_reg;
  logic cfg_sync_reg;
  logic rdo_meta_reg;
  logic rdo_sync_reg;
  logic rdo_prev_reg;
  logic chain_meta_reg;
  logic chain_sync_reg;
  logic rdo_fall;

  // First stage on the falling edge so the host sees falling-edge capture
  always_ff @(negedge ref_clk) begin
    if (!rst_n) begin
      cfg_meta_reg <= 1'b0;
    end else if (clk_en) begin
      cfg_meta_reg <= config_serial_in;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cfg_sync_reg <= 1'b0;
    end else if (clk_en) begin
      cfg_sync_reg <= cfg_meta_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdo_meta_reg <= 1'b0;
      rdo_sync_reg <= 1'b0;
      rdo_prev_reg <= 1'b0;
    end else if (clk_en) begin
      rdo_meta_reg <= readout_clock;
      rdo_sync_reg <= rdo_meta_reg;
      rdo_prev_reg <= rdo_sync_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      chain_meta_reg <= 1'b0;
      chain_sync_reg <= 1'b0;
    end else if (clk_en) begin
      chain_meta_reg <= chain_serial_in;
      chain_sync_reg <= chain_meta_reg;
    end
  end

  assign rdo_fall = rdo_prev_reg & ~rdo_sync_reg;

  ////////////////////////////////////////////////////////////////////////
  // Serial configuration write

  logic [adccr_pkg::FRAME_BITS-1:0] cfg_shift_reg;
  logic [4:0] cfg_count_reg;
  logic [adccr_pkg::FRAME_BITS-1:0] cfg_window;
  logic cfg_load;
  logic [15:0] cfg_reg;

  assign cfg_window = {cfg_shift_reg[adccr_pkg::FRAME_BITS-2:0], cfg_sync_reg};

  // A full frame has been seen and its leading four bits match the key
  assign cfg_load = (cfg_count_reg == adccr_pkg::FRAME_BITS_5 - 5'h01)
                    && (cfg_window[adccr_pkg::FRAME_BITS-1 -: adccr_pkg::PREAMBLE_BITS]
                        == adccr_pkg::PREAMBLE_KEY);

  // The window keeps sliding once full, so a late preamble still lines up
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cfg_shift_reg <= '0;
      cfg_count_reg <= 5'h00;
    end else if (clk_en) begin
      if (cfg_load) begin
        cfg_shift_reg <= '0;
        cfg_count_reg <= 5'h00;
      end else begin
        cfg_shift_reg <= cfg_window;
        if (cfg_count_reg != adccr_pkg::FRAME_BITS_5 - 5'h01) begin
          cfg_count_reg <= cfg_count_reg + 5'h01;
        end
      end
    end
  end

  // Stored exactly as written; reserved bits are not policed
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cfg_reg <= adccr_pkg::CFG_RESET;
    end else if (clk_en && cfg_load) begin
      cfg_reg <= cfg_window[adccr_pkg::CFG_WIDTH-1:0];
    end
  end

  // Range, speed, test and buffer fields drive the analog core as stored
  assign converter_configuration = adccr_pkg::adccr_cfg_t'(cfg_reg);

  ////////////////////////////////////////////////////////////////////////
  // Field decode

  logic tdm_mode;
  logic [1:0] resol_code;
  int word_bits;

  assign tdm_mode = cfg_reg[adccr_pkg::CFG_BIT_MODE];
  assign resol_code = cfg_reg[adccr_pkg::CFG_BIT_RESOL_HI:adccr_pkg::CFG_BIT_RESOL_LO];

  always_comb begin
    case (resol_code)
      adccr_pkg::RESOL_CODE_16: word_bits = adccr_pkg::RESOL16_BITS;
      adccr_pkg::RESOL_CODE_14: word_bits = adccr_pkg::RESOL14_BITS;
      default: word_bits = adccr_pkg::RESOL12_BITS;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Result packing

  // Takes the top wbits of each word, channels in ascending order, packed
  // from the MSB down; the unused tail is zero so short words shorten reads.
  function automatic logic [adccr_pkg::TDM_BITS-1:0] pack_words(
    input logic [adccr_pkg::TDM_BITS-1:0] flat,
    input int first,
    input int count,
    input int wbits
  );
    logic [adccr_pkg::TDM_BITS-1:0] v;
    int pos;
    v = '0;
    pos = adccr_pkg::TDM_BITS - 1;
    for (int c = 0; c < adccr_pkg::NUM_CHANNELS; c++) begin
      for (int b = 0; b < adccr_pkg::WORD_BITS; b++) begin
        if (c < count && b < wbits) begin
          v[pos] = flat[adccr_pkg::TDM_BITS - 1 - adccr_pkg::WORD_BITS * (first + c) - b];
          pos = pos - 1;
        end
      end
    end
    return v;
  endfunction

  logic [adccr_pkg::TDM_BITS-1:0] tdm_image;
  logic [adccr_pkg::TDM_BITS-1:0] lane_image [adccr_pkg::NUM_LANES];

  assign tdm_image = pack_words(adc_results, 0, adccr_pkg::NUM_CHANNELS, word_bits);

  ////////////////////////////////////////////////////////////////////////
  // Output lanes

  logic [adccr_pkg::NUM_LANES-1:0] lane_bit;
  logic lane_load;

  // A configuration update and a conversion both reload; in one cycle the configuration word wins
  assign lane_load = cfg_load | adc_results_valid;

  generate
    for (genvar k = 0; k < adccr_pkg::NUM_LANES; k++) begin : g_lane
      if (k == 0) begin : g_first
        logic [adccr_pkg::TDM_BITS-1:0] load_word;
        logic chain_bit;
        always_comb begin
          lane_image[k] = pack_words(adc_results, 0, adccr_pkg::CH_PER_LANE, word_bits);
          if (cfg_load) begin
            load_word = {cfg_window[adccr_pkg::CFG_WIDTH-1:0],
                         {(adccr_pkg::TDM_BITS - adccr_pkg::CFG_WIDTH){1'b0}}};
          end else if (tdm_mode) begin
            load_word = tdm_image;
          end else begin
            load_word = lane_image[k];
          end
        end
        // Chained data only makes sense behind the full multiplexed stream
        assign chain_bit = tdm_mode & chain_sync_reg;
        adccr_lane #(
          .WIDTH(adccr_pkg::TDM_BITS)
        ) u_lane (
          .ref_clk(ref_clk),
          .rst_n(rst_n),
          .clk_en(clk_en),
          .load(lane_load),
          .load_data(load_word),
          .shift(rdo_fall),
          .shift_in(chain_bit),
          .data_out(lane_bit[k])
        );
      end else begin : g_other
        logic [adccr_pkg::LANE_BITS-1:0] load_word;
        always_comb begin
          lane_image[k] = pack_words(adc_results, k * adccr_pkg::CH_PER_LANE,
                                     adccr_pkg::CH_PER_LANE, word_bits);
          if (tdm_mode || cfg_load) begin
            load_word = '0;
          end else begin
            load_word = lane_image[k][adccr_pkg::TDM_BITS-1 -: adccr_pkg::LANE_BITS];
          end
        end
        adccr_lane #(
          .WIDTH(adccr_pkg::LANE_BITS)
        ) u_lane (
          .ref_clk(ref_clk),
          .rst_n(rst_n),
          .clk_en(clk_en),
          .load(lane_load),
          .load_data(load_word),
          .shift(rdo_fall),
          .shift_in(1'b0),
          .data_out(lane_bit[k])
        );
      end
    end
  endgenerate

  assign data_out.data_out_lane1 = lane_bit[0];
  assign data_out.data_out_lane2 = lane_bit[1];
  assign data_out.data_out_lane3 = lane_bit[2];
  assign data_out.data_out_lane4 = lane_bit[3];

  ////////////////////////////////////////////////////////////////////////
  // Result ready

  // A load in the same cycle as a readout fall wins: new data must not be
  // reported as already taken.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      result_ready_n <= 1'b1;
    end else if (clk_en) begin
      if (lane_load) begin
        result_ready_n <= 1'b0;
      end else if (rdo_fall) begin
        result_ready_n <= 1'b1;
      end
    end
  end

endmodule

// ### hdl/adccr_pkg.sv
package adccr_pkg;

  // Configuration word layout
  localparam int CFG_WIDTH = 16;
  localparam int CFG_BIT_ONE = 15;
  localparam int CFG_BIT_MODE = 14;
  localparam int CFG_BIT_RESOL_HI = 13;
  localparam int CFG_BIT_RESOL_LO = 12;
  localparam int CFG_BIT_RANGE_HI = 11;
  localparam int CFG_BIT_RANGE_LO = 10;
  localparam int CFG_BIT_SPEED = 8;
  localparam int CFG_BIT_TEST_HI = 7;
  localparam int CFG_BIT_TEST_LO = 6;
  localparam int CFG_BIT_BUF = 4;

  // Defaults: normal speed and reference buffer off, all else zero
  localparam logic [15:0] CFG_RESET = 16'h0110;

  // Serial write framing
  localparam int PREAMBLE_BITS = 4;
  localparam logic [3:0] PREAMBLE_KEY = 4'hA;
  localparam int FRAME_BITS = PREAMBLE_BITS + CFG_WIDTH;
  localparam logic [4:0] FRAME_BITS_5 = 5'h14;

  // Result geometry
  localparam int NUM_CHANNELS = 16;
  localparam int NUM_LANES = 4;
  localparam int CH_PER_LANE = NUM_CHANNELS / NUM_LANES;
  localparam int WORD_BITS = 16;
  localparam int TDM_BITS = NUM_CHANNELS * WORD_BITS;
  localparam int LANE_BITS = CH_PER_LANE * WORD_BITS;

  // Word width per resolution code
  localparam int RESOL16_BITS = 16;
  localparam int RESOL14_BITS = 14;
  localparam int RESOL12_BITS = 12;
  localparam logic [1:0] RESOL_CODE_16 = 2'h0;
  localparam logic [1:0] RESOL_CODE_14 = 2'h1;

  // Integration minimums in system clock periods (kept by the host)
  localparam int MIN_INT_FAST_CLKS = 400;
  localparam int MIN_INT_NORMAL_CLKS = 800;

  typedef struct packed {
    logic always_one;
    logic out_mode;
    logic [1:0] resolution_select;
    logic [1:0] charge_range;
    logic zero_9;
    logic normal_speed_select;
    logic [1:0] test_function_select;
    logic zero_5;
    logic ref_buffer_off;
    logic [3:0] zero_3_0;
  } adccr_cfg_t;

  typedef struct packed {
    logic data_out_lane1;
    logic data_out_lane2;
    logic data_out_lane3;
    logic data_out_lane4;
  } adccr_dout_t;

endpackage

// ### hdl/adccr_lane.sv
`timescale 1ns/100ps
module adccr_lane #(
  parameter int WIDTH = 64
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_data,
  input wire logic shift,
  input wire logic shift_in,
  output logic data_out
);

  logic [WIDTH-1:0] shift_reg;

  // Load wins over shift so fresh data is never half shifted
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      shift_reg <= '0;
    end else if (clk_en) begin
      if (load) begin
        shift_reg <= load_data;
      end else if (shift) begin
        shift_reg <= {shift_reg[WIDTH-2:0], shift_in};
      end
    end
  end

  assign data_out = shift_reg[WIDTH-1];

endmodule

// ### dv/adccr_monitor.sv
`timescale 1ns/100ps
module adccr_monitor (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic config_serial_in,
  input wire logic readout_clock,
  input wire logic adc_results_valid,
  input wire logic [adccr_pkg::TDM_BITS-1:0] adc_results,
  input wire adccr_pkg::adccr_cfg_t converter_configuration,
  input wire adccr_pkg::adccr_dout_t data_out,
  input wire logic result_ready_n
);
  default clocking mcb @(posedge ref_clk);
  endclocking
  logic rst_q;
  // Also off for the release edge, where past values still hold pre-reset state
  always_ff @(posedge ref_clk) begin
    rst_q <= rst_n;
  end
  default disable iff (!rst_n || !rst_q);
  logic [4:0] idle_cnt;
  logic [3:0] fall_cnt;
  logic rc_q;
  // A load needs ones in the preamble, so a long quiet pin means no load
  always_ff @(posedge ref_clk) begin
    if (!rst_n || config_serial_in) idle_cnt <= 5'h0;
    else if (idle_cnt != 5'h1F) idle_cnt <= idle_cnt + 5'h1;
  end
  always_ff @(posedge ref_clk) begin
    rc_q <= readout_clock;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n || (rc_q && !readout_clock)) fall_cnt <= 4'h0;
    else if (fall_cnt != 4'hF) fall_cnt <= fall_cnt + 4'h1;
  end
  a_reset_values: assert property ($rose(rst_n) |-> converter_configuration == 16'h0110
    && data_out == 4'h0 && result_ready_n) else $error("outputs wrong after reset");
  a_tdm_lanes_low: assert property (converter_configuration.out_mode |-> data_out[2:0] == 3'h0)
    else $error("lanes 2 to 4 active in multiplexed mode");
  a_cfg_readback: assert property ($changed(converter_configuration) |-> !result_ready_n
    && data_out.data_out_lane1 == converter_configuration[15] && data_out[2:0] == 3'h0)
    else $error("config word not presented on lane 1");
  a_cfg_idle_stable: assert property (idle_cnt >= 5'h1E |-> $stable(converter_configuration))
    else $error("config changed with idle pin");
  a_result_msb: assert property (adc_results_valid |=> !result_ready_n
    && data_out.data_out_lane1 == $past(adc_results[255])) else $error("result msb not first");
  a_ready_rises: assert property ($fell(readout_clock) && !result_ready_n && !adc_results_valid
    |-> ##[1:6] result_ready_n) else $error("ready not released by readout fall");
  a_shift_on_fall: assert property (fall_cnt >= 4'h6 && !$past(adc_results_valid)
    && $stable(converter_configuration) |-> $stable(data_out)) else $error("lanes moved without fall");
  a_ready_cause: assert property ($fell(result_ready_n) |-> $past(adc_results_valid)
    || $changed(converter_configuration)) else $error("ready fell without a load");
endmodule
bind adccr_top adccr_monitor mon (.ref_clk, .rst_n, .config_serial_in, .readout_clock,
  .adc_results_valid, .adc_results, .converter_configuration, .data_out, .result_ready_n);

// ### dv/adccr_host.sv
`timescale 1ns/100ps
module adccr_host (
  input wire logic ref_clk,
  input wire adccr_pkg::adccr_dout_t data_out,
  output logic config_serial_in,
  output logic readout_clock
);
  logic [255:0] lane_sr [4];
  initial begin
    config_serial_in = 1'h0;
    readout_clock = 1'h0;
  end
  // Launched on the rising edge so each bit is settled at the falling-edge sample
  task automatic send_frame(input logic [19:0] frame);
    for (int i = 19; i >= 0; i--) begin
      @(posedge ref_clk);
      config_serial_in <= frame[i];
    end
    @(posedge ref_clk);
    config_serial_in <= 1'h0;
  endtask
  // 80 ns link clock, five system clocks per phase, parked low outside a readout
  task automatic read_bits(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (5) @(posedge ref_clk);
      readout_clock <= 1'h1;
      for (int k = 0; k < 4; k++) lane_sr[k] = {lane_sr[k][254:0], data_out[3-k]};
      repeat (5) @(posedge ref_clk);
      readout_clock <= 1'h0;
    end
  endtask
endmodule

// ### dv/adccr_top_test.sv
`timescale 1ns/100ps
module adccr_top_test;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic adc_results_valid = 1'h0;
  logic [255:0] adc_results = 256'h0;
  logic config_serial_in;
  logic readout_clock;
  logic chain_in = 1'h0;
  adccr_pkg::adccr_cfg_t cfg;
  adccr_pkg::adccr_dout_t dout;
  logic ready_n;
  int err_total = 0;
  int n_compared = 0;
  always #4 ref_clk = ~ref_clk;
  adccr_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'h1), .config_serial_in(config_serial_in),
    .readout_clock(readout_clock), .chain_serial_in(chain_in), .adc_results_valid(adc_results_valid),
    .adc_results(adc_results), .converter_configuration(cfg), .data_out(dout), .result_ready_n(ready_n));
  adccr_host host (.ref_clk(ref_clk), .data_out(dout), .config_serial_in(config_serial_in),
    .readout_clock(readout_clock));
  ////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [255:0] exp, input logic [255:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 40; i++) begin
      if (ready_n === 1'h0) return;
      @(posedge ref_clk);
    end
    err_total++;
    $display("MISMATCH result_ready_n expected 0 seen %b", ready_n);
    summarize();
  endtask
  // Words kept from each channel, channels ascending, top bits of each word
  function automatic logic [255:0] expect_lane(input int k, input logic tdm, input int nb);
    logic [255:0] acc;
    logic [15:0] w;
    acc = 256'h0;
    if (tdm && k > 0) return acc;
    for (int c = 0; c < (tdm ? 16 : 4); c++) begin
      w = adc_results[255 - 16 * (c + (tdm ? 0 : 4 * k)) -: 16];
      acc = (acc << nb) | 256'(w >> (16 - nb));
    end
    return acc;
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] word;
    int nb;
    int n;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge ref_clk);
    check("config after reset", 256'h0110, 256'(cfg));
    check("ready after reset", 256'h1, 256'(ready_n));
    check("lanes after reset", 256'h0, 256'(dout));
    $display("test reset done");
    host.send_frame({4'hA, 16'hC23F});
    wait_ready();
    check("config reserved", 256'hC23F, 256'(cfg));
    host.read_bits(16);
    check("lane1 readback", 256'hC23F, 256'(host.lane_sr[0][15:0]));
    check("lanes 2-4 readback", 256'h0, {host.lane_sr[1][15:0], host.lane_sr[2][15:0], host.lane_sr[3][15:0]});
    repeat (6) @(posedge ref_clk);
    check("ready after readout", 256'h1, 256'(ready_n));
    $display("test readback done");
    host.send_frame({4'hB, 16'h8000});
    repeat (8) @(posedge ref_clk);
    check("config bad key", 256'hC23F, 256'(cfg));
    check("ready bad key", 256'h1, 256'(ready_n));
    $display("test preamble done");
    chain_in <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      // Fast operation only together with 12-bit words
      word = {1'h1, i[0], i[1:0], i[1:0], 1'h0, i[0] | ~i[1], i[1:0], 1'h0, i[1], 4'h0};
      host.send_frame({4'hA, word});
      wait_ready();
      check("config fields", 256'(word), 256'(cfg));
      host.read_bits(16);
      check("mode readback", 256'(word), 256'(host.lane_sr[0][15:0]));
      if (word[adccr_pkg::CFG_BIT_SPEED]) begin
        repeat (adccr_pkg::MIN_INT_NORMAL_CLKS) @(posedge ref_clk);
      end else begin
        repeat (adccr_pkg::MIN_INT_FAST_CLKS) @(posedge ref_clk);
      end
      check("ready before conversion", 256'h1, 256'(ready_n));
      @(posedge ref_clk);
      for (int c = 0; c < 16; c++) adc_results[255 - 16 * c -: 16] <= 16'(16'h4C1D + (c + i) * 16'h9E37);
      adc_results_valid <= 1'h1;
      @(posedge ref_clk);
      adc_results_valid <= 1'h0;
      wait_ready();
      nb = (i == 0) ? 16 : (i == 1) ? 14 : 12;
      n = i[0] ? 16 * nb : 4 * nb;
      host.read_bits(n);
      for (int k = 0; k < 4; k++) check("lane data", expect_lane(k, i[0], nb), host.lane_sr[k] & ((256'h1 << n) - 256'h1));
      // Chained bits follow the full 256-bit register, and only in multiplexed mode
      if (i[1]) begin
        host.read_bits(257 - n);
        check("chain bits", 256'({1'h0, i[0]}), 256'(host.lane_sr[0][1:0]));
      end
      $display("test mode %0d done", i);
    end
    rst_n <= 1'h0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge ref_clk);
    check("config after mid reset", 256'(adccr_pkg::CFG_RESET), 256'(cfg));
    check("ready after mid reset", 256'h1, 256'(ready_n));
    check("lanes after mid reset", 256'h0, 256'(dout));
    $display("test mid reset done");
    summarize();
  end
endmodule
